// ===== hdl/ulpswk_pkg.sv
// Package with states, modes, triggers, timing constants and carriers of the wakeup controller
`default_nettype none
package ulpswk_pkg;
    typedef enum logic [2:0] {
        ST_OFF, ST_BOOT, ST_ACTIVE, ST_SLEEP, ST_EPOFF
    } ulpswk_state_t;

    localparam logic [1:0] MODE_ULPM = 2'h0;
    localparam logic [1:0] MODE_PSM = 2'h1;

    localparam logic [1:0] AN_ABOVE = 2'h0;
    localparam logic [1:0] AN_BELOW = 2'h1;
    localparam logic [1:0] AN_INSIDE = 2'h2;
    localparam logic [1:0] AN_OUTSIDE = 2'h3;

    localparam logic [2:0] PIN_OFF = 3'h0;
    localparam logic [2:0] PIN_HIGH = 3'h1;
    localparam logic [2:0] PIN_LOW = 3'h2;
    localparam logic [2:0] PIN_RISE = 3'h3;
    localparam logic [2:0] PIN_FALL = 3'h4;
    localparam logic [2:0] PIN_BOTH = 3'h5;

    localparam int TIMER_W = 32;
    localparam int ANALOG_W = 12;
    localparam int BOOT_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [TIMER_W-1:0] TIMER_MARGIN = 32'h0000_0040;

    localparam int SRC_CYCLE = 0;
    localparam int SRC_LOCAL = 1;
    localparam int SRC_ANALOG = 2;
    localparam int SRC_PIN_A = 3;
    localparam int SRC_PIN_B = 4;
    localparam int SRC_RESET = 5;
    localparam int SRC_POWER = 6;
    localparam int SRC_N = 7;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_CYCLE = 32'h0000_0004;
    localparam logic [31:0] ADDR_LOCAL = 32'h0000_0008;
    localparam logic [31:0] ADDR_ANALOG = 32'h0000_000C;
    localparam logic [31:0] ADDR_PINCFG = 32'h0000_0010;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0014;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic enable;
        logic channelB;
        logic [1:0] kind;
        logic [ANALOG_W-1:0] low;
        logic [ANALOG_W-1:0] high;
    } ulpswk_analog_t;

    typedef struct packed {
        logic [2:0] trigB;
        logic [2:0] trigA;
    } ulpswk_pincfg_t;
endpackage
`default_nettype wire

// ===== hdl/ulpswk_pin_trig.sv
// One wake pin: synchroniser plus level and edge trigger detection
`default_nettype none
module ulpswk_pin_trig (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin and mode
    input wire logic pinIn,
    input wire logic [2:0] trigMode,
    // Trigger
    output logic hit
);
    logic sync1Reg;
    logic sync2Reg;
    logic prevReg;
    logic rise;
    logic fall;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1Reg <= 1'b0;
            sync2Reg <= 1'b0;
            prevReg <= 1'b0;
        end else begin
            sync1Reg <= pinIn;
            sync2Reg <= sync1Reg;
            prevReg <= sync2Reg;
        end
    end

    assign rise = sync2Reg & ~prevReg;
    assign fall = ~sync2Reg & prevReg;
    assign hit = (trigMode == ulpswk_pkg::PIN_HIGH && sync2Reg)
              || (trigMode == ulpswk_pkg::PIN_LOW && !sync2Reg)
              || (trigMode == ulpswk_pkg::PIN_RISE && rise)
              || (trigMode == ulpswk_pkg::PIN_FALL && fall)
              || (trigMode == ulpswk_pkg::PIN_BOTH && (rise || fall));
endmodule
`default_nettype wire

// ===== hdl/ulpswk_ctrl.sv
// Wakeup and power-state controller with AXI4-Lite configuration slave
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
module ulpswk_ctrl #(
    parameter int BOOT_CYCLES = ulpswk_pkg::BOOT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Board pins, power and reset active low as on the board
    input wire logic powerOnReq_n,
    input wire logic resetIn_n,
    input wire logic wakePinA,
    input wire logic wakePinB,
    // Analog comparator samples from the two channels
    input wire logic [ulpswk_pkg::ANALOG_W-1:0] analogA,
    input wire logic [ulpswk_pkg::ANALOG_W-1:0] analogB,
    // Protocol stack: application sleep request, psm inactive period start
    input wire logic sleepReq,
    input wire logic psmIdle,
    // Power status
    output logic coreOn,
    output logic coreReset,
    output logic emergencyOff,
    output logic inSleep
);
    localparam int TW = ulpswk_pkg::TIMER_W;
    localparam int AW = ulpswk_pkg::ANALOG_W;

    ulpswk_pkg::ulpswk_state_t stateReg, stateNext;
    logic [1:0] startedReg;
    logic [1:0] modeReg;
    logic localEnReg;
    logic [TW-1:0] cycleTimeReg, localTimeReg, cycleCntReg, localCntReg;
    ulpswk_pkg::ulpswk_analog_t analogReg;
    ulpswk_pkg::ulpswk_pincfg_t pinCfgReg;
    logic [AW-1:0] anSyncReg, anValReg;
    logic [2:0] pwrSyncReg;
    logic [1:0] rstSyncReg;
    logic wakeReg;
    logic [ulpswk_pkg::SRC_N-1:0] causeReg;
    logic [15:0] bootCntReg;
    logic awHeld, wHeld;
    logic [31:0] awAddrReg, wDataReg;

    // Synchronised pin levels: stage 0 only feeds stage 1
    logic powerOn, powerOnPrev, resetAsserted;
    assign powerOn = pwrSyncReg[1];
    assign powerOnPrev = pwrSyncReg[2];
    assign resetAsserted = !rstSyncReg[1];

    logic hitA, hitB;
    ulpswk_pin_trig uPinA (.mclk(mclk), .rst_n(rst_n), .pinIn(wakePinA), .trigMode(pinCfgReg.trigA), .hit(hitA));
    ulpswk_pin_trig uPinB (.mclk(mclk), .rst_n(rst_n), .pinIn(wakePinB), .trigMode(pinCfgReg.trigB), .hit(hitB));

    // Analog compare on the one configured channel
    logic anAbove, anBelow, anInside, anHit;
    assign anAbove = anValReg > analogReg.high;
    assign anBelow = anValReg < analogReg.low;
    assign anInside = !anAbove && !anBelow;
    assign anHit = analogReg.enable && (
        (analogReg.kind == ulpswk_pkg::AN_ABOVE && anAbove)
        || (analogReg.kind == ulpswk_pkg::AN_BELOW && anBelow)
        || (analogReg.kind == ulpswk_pkg::AN_INSIDE && anInside)
        || (analogReg.kind == ulpswk_pkg::AN_OUTSIDE && !anInside));

    logic isPsm, sleeping, cycleExp, localExp;
    assign isPsm = modeReg == ulpswk_pkg::MODE_PSM;
    assign sleeping = stateReg == ulpswk_pkg::ST_SLEEP;
    assign cycleExp = isPsm && cycleCntReg == '0;
    assign localExp = (localEnReg || isPsm) && localCntReg == '0;

    logic [ulpswk_pkg::SRC_N-1:0] srcVec;
    assign srcVec[ulpswk_pkg::SRC_CYCLE] = cycleExp;
    assign srcVec[ulpswk_pkg::SRC_LOCAL] = localExp;
    assign srcVec[ulpswk_pkg::SRC_ANALOG] = anHit;
    assign srcVec[ulpswk_pkg::SRC_PIN_A] = hitA;
    assign srcVec[ulpswk_pkg::SRC_PIN_B] = hitB;
    assign srcVec[ulpswk_pkg::SRC_RESET] = resetAsserted && powerOn;
    assign srcVec[ulpswk_pkg::SRC_POWER] = powerOn && !powerOnPrev;
    logic anyWake;
    assign anyWake = sleeping && |srcVec;

    // Local timer in psm sits a margin below the cycle timer
    logic [TW-1:0] localLoad;
    assign localLoad = isPsm ? ((cycleTimeReg > ulpswk_pkg::TIMER_MARGIN) ?
        cycleTimeReg - ulpswk_pkg::TIMER_MARGIN : TW'(1)) : localTimeReg;

    logic enterSleep;
    assign enterSleep = stateReg == ulpswk_pkg::ST_ACTIVE && (isPsm ? psmIdle : sleepReq);

    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ulpswk_pkg::ST_OFF: begin
                // Decide only once the power pin has crossed its synchroniser
                if (startedReg[1]) begin
                    stateNext = powerOn ? ulpswk_pkg::ST_BOOT : ulpswk_pkg::ST_SLEEP;
                end
            end
            ulpswk_pkg::ST_BOOT: begin
                if (bootCntReg == 16'(BOOT_CYCLES - 1)) begin
                    stateNext = ulpswk_pkg::ST_ACTIVE;
                end
            end
            ulpswk_pkg::ST_ACTIVE: begin
                if (resetAsserted && !powerOn) begin
                    stateNext = ulpswk_pkg::ST_EPOFF;
                end else if (resetAsserted) begin
                    stateNext = ulpswk_pkg::ST_BOOT;
                end else if (enterSleep) begin
                    stateNext = ulpswk_pkg::ST_SLEEP;
                end
            end
            ulpswk_pkg::ST_SLEEP: begin
                if (resetAsserted && !powerOn) begin
                    stateNext = ulpswk_pkg::ST_EPOFF;
                end else if (wakeReg) begin
                    stateNext = ulpswk_pkg::ST_BOOT;
                end
            end
            ulpswk_pkg::ST_EPOFF: begin
                if (powerOn && !powerOnPrev) begin
                    stateNext = ulpswk_pkg::ST_BOOT;
                end
            end
            default: stateNext = ulpswk_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stateReg <= ulpswk_pkg::ST_OFF;
            startedReg <= 2'h0;
            pwrSyncReg <= '0;
            rstSyncReg <= 2'h3;
            anSyncReg <= '0;
            anValReg <= '0;
            wakeReg <= 1'b0;
            causeReg <= '0;
            bootCntReg <= '0;
            cycleCntReg <= '0;
            localCntReg <= '0;
        end else begin
            stateReg <= stateNext;
            startedReg <= {startedReg[0], 1'b1};
            pwrSyncReg <= {pwrSyncReg[1:0], !powerOnReq_n};
            rstSyncReg <= {rstSyncReg[0], resetIn_n};
            anSyncReg <= analogReg.channelB ? analogB : analogA;
            anValReg <= anSyncReg;
            if (anyWake) begin
                wakeReg <= 1'b1;
                causeReg <= causeReg | srcVec;
            end else if (stateReg == ulpswk_pkg::ST_BOOT) begin
                wakeReg <= 1'b0;
            end
            if (enterSleep) begin
                causeReg <= '0;
            end
            bootCntReg <= (stateReg == ulpswk_pkg::ST_BOOT) ? bootCntReg + 16'h0001 : 16'h0000;
            if (stateNext == ulpswk_pkg::ST_SLEEP && !sleeping) begin
                cycleCntReg <= cycleTimeReg;
                localCntReg <= localLoad;
            end else if (sleeping) begin
                if (cycleCntReg != '0) cycleCntReg <= cycleCntReg - TW'(1);
                if (localCntReg != '0) localCntReg <= localCntReg - TW'(1);
            end
        end
    end

    // AXI4-Lite slave: accepts address and data in either order
    logic doWrite;
    logic [31:0] wrAddr, wrData;
    assign wrAddr = awHeld ? awAddrReg : s_axi_awaddr;
    assign wrData = wHeld ? wDataReg : s_axi_wdata;
    assign doWrite = (awHeld || (s_axi_awvalid && s_axi_awready))
                  && (wHeld || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    logic wrHit;
    assign wrHit = wrAddr == ulpswk_pkg::ADDR_CTRL || wrAddr == ulpswk_pkg::ADDR_CYCLE
                || wrAddr == ulpswk_pkg::ADDR_LOCAL || wrAddr == ulpswk_pkg::ADDR_ANALOG
                || wrAddr == ulpswk_pkg::ADDR_PINCFG;
    logic [31:0] rdMux;
    logic rdHit;
    always_comb begin
        rdMux = '0;
        rdHit = 1'b1;
        case (s_axi_araddr)
            ulpswk_pkg::ADDR_CTRL: rdMux = {29'h0, localEnReg, modeReg};
            ulpswk_pkg::ADDR_CYCLE: rdMux = cycleTimeReg;
            ulpswk_pkg::ADDR_LOCAL: rdMux = localTimeReg;
            ulpswk_pkg::ADDR_ANALOG: rdMux = {4'h0, analogReg};
            ulpswk_pkg::ADDR_PINCFG: rdMux = {26'h0, pinCfgReg};
            ulpswk_pkg::ADDR_STATUS: rdMux = {22'h0, causeReg, stateReg};
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ulpswk_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= ulpswk_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= '0;
            wDataReg <= '0;
            modeReg <= ulpswk_pkg::MODE_ULPM;
            localEnReg <= 1'b0;
            cycleTimeReg <= '0;
            localTimeReg <= '0;
            analogReg <= '0;
            pinCfgReg <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrReg <= s_axi_awaddr;
                awHeld <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataReg <= s_axi_wdata;
                wHeld <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? ulpswk_pkg::RESP_OKAY : ulpswk_pkg::RESP_SLVERR;
                // config only changes by software, never by sleep cycles
                if (s_axi_wstrb == 4'hF) begin
                    case (wrAddr)
                        ulpswk_pkg::ADDR_CTRL: begin
                            modeReg <= wrData[1:0];
                            localEnReg <= wrData[2];
                        end
                        ulpswk_pkg::ADDR_CYCLE: cycleTimeReg <= wrData;
                        ulpswk_pkg::ADDR_LOCAL: localTimeReg <= wrData;
                        ulpswk_pkg::ADDR_ANALOG: analogReg <= wrData[27:0];
                        ulpswk_pkg::ADDR_PINCFG: pinCfgReg <= wrData[5:0];
                        default: ;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdHit ? ulpswk_pkg::RESP_OKAY : ulpswk_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            coreOn <= 1'b0;
            coreReset <= 1'b1;
            emergencyOff <= 1'b0;
            inSleep <= 1'b0;
        end else begin
            coreOn <= stateNext == ulpswk_pkg::ST_BOOT || stateNext == ulpswk_pkg::ST_ACTIVE;
            coreReset <= stateNext != ulpswk_pkg::ST_ACTIVE;
            emergencyOff <= stateNext == ulpswk_pkg::ST_EPOFF;
            inSleep <= stateNext == ulpswk_pkg::ST_SLEEP;
        end
    end

    a_sleep_wakes_boot: assert property (@(posedge mclk) disable iff (!rst_n)
        sleeping && wakeReg && !(resetAsserted && !powerOn) |=> stateReg == ulpswk_pkg::ST_BOOT)
        else $error("wake did not start boot");
    a_wake_held: assert property (@(posedge mclk) disable iff (!rst_n)
        anyWake |=> wakeReg)
        else $error("wake request lost");
    a_epoff_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        stateReg == ulpswk_pkg::ST_SLEEP && resetAsserted && !powerOn |=> emergencyOff)
        else $error("no emergency off");
    a_first_state: assert property (@(posedge mclk) disable iff (!rst_n)
        stateReg == ulpswk_pkg::ST_OFF && startedReg[1] && powerOn |=> stateReg == ulpswk_pkg::ST_BOOT)
        else $error("power-up choice wrong");
    a_boot_len: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(stateReg == ulpswk_pkg::ST_BOOT) |-> ##[1:300] stateReg != ulpswk_pkg::ST_BOOT)
        else $error("boot too long");
    a_sleep_on_req: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(sleeping) && !isPsm && $past(stateReg) == ulpswk_pkg::ST_ACTIVE |-> $past(sleepReq))
        else $error("sleep without request");
    a_psm_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        sleeping && cycleExp |=> wakeReg || stateReg != ulpswk_pkg::ST_SLEEP)
        else $error("cycle timer ignored");
    a_power_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        sleeping && powerOn && !powerOnPrev |=> wakeReg)
        else $error("power-on edge ignored");
    c_wake_cycle: cover property (@(posedge mclk) disable iff (!rst_n) sleeping ##1 stateReg == ulpswk_pkg::ST_BOOT);
    c_epoff: cover property (@(posedge mclk) disable iff (!rst_n) emergencyOff);
    c_analog: cover property (@(posedge mclk) disable iff (!rst_n) anyWake && anHit);
endmodule
`default_nettype wire

// ===== dv/ulpswk_board.sv
// Host board model driving power, reset, wake pins and analog levels
`default_nettype none
module ulpswk_board (
    // Clock
    input wire logic mclk,
    // Board pins
    output logic powerOnReq_n,
    output logic resetIn_n,
    output logic wakePinA,
    output logic wakePinB,
    output logic [ulpswk_pkg::ANALOG_W-1:0] analogA,
    output logic [ulpswk_pkg::ANALOG_W-1:0] analogB
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        powerOnReq_n = 1'b1;
        resetIn_n = 1'b1;
        wakePinA = 1'b0;
        wakePinB = 1'b0;
        analogA = 12'h000;
        analogB = 12'h000;
    end
    task automatic setPower(input logic on);
        @(posedge mclk);
        powerOnReq_n <= ~on;
    endtask
    // Reset held long enough to pass the pin synchroniser
    task automatic pulseReset();
        @(posedge mclk);
        resetIn_n <= 1'b0;
        repeat (4) @(posedge mclk);
        resetIn_n <= 1'b1;
    endtask
    task automatic setPin(input int p, input logic v);
        @(posedge mclk);
        if (p == 0) wakePinA <= v;
        else wakePinB <= v;
    endtask
    task automatic setAnalog(input int ch, input logic [11:0] v);
        @(posedge mclk);
        if (ch == 0) analogA <= v;
        else analogB <= v;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_ulpswk_ctrl.sv
// Self-checking bench of the wakeup controller
`default_nettype none
module tb_ulpswk_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BOOT = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awAddr = 32'h0000_0000, wData = 32'h0000_0000, arAddr = 32'h0000_0000;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, coreOn, coreReset, emergencyOff, inSleep;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic sleepReq = 1'b0, psmIdle = 1'b0;
    logic powerOnReq_n, resetIn_n, wakePinA, wakePinB;
    logic [11:0] analogA, analogB;
    int fails = 0, samples_checked = 0;
    always #20 mclk = ~mclk;
    ulpswk_board ulpswk_board_i (.mclk(mclk), .powerOnReq_n(powerOnReq_n), .resetIn_n(resetIn_n),
        .wakePinA(wakePinA), .wakePinB(wakePinB), .analogA(analogA), .analogB(analogB));
    ulpswk_ctrl #(.BOOT_CYCLES(BOOT)) ulpswk_ctrl_i (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .powerOnReq_n(powerOnReq_n), .resetIn_n(resetIn_n), .wakePinA(wakePinA),
        .wakePinB(wakePinB), .analogA(analogA), .analogB(analogB), .sleepReq(sleepReq), .psmIdle(psmIdle),
        .coreOn(coreOn), .coreReset(coreReset), .emergencyOff(emergencyOff), .inSleep(inSleep));
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic timeout();
        fails++;
        $display("Error wait expected done seen timeout");
        test_done();
    endtask
    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge mclk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (bValid) break;
        end
        bReady <= 1'b0;
        resp = bResp;
        if (n == 50) timeout();
    endtask
    task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arReady) arValid <= 1'b0;
            if (rValid) break;
        end
        rReady <= 1'b0;
        d = rData;
        resp = rResp;
        if (n == 50) timeout();
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axiWrite(a, d, r);
        check("bresp", 32'(r), 32'(ulpswk_pkg::RESP_OKAY));
    endtask
    // Sel 0 waits for Active, 1 for deep sleep, 2 for emergency off
    task automatic waitFor(input int sel, input int bound, output int cnt);
        for (cnt = 0; cnt < bound; cnt++) begin
            @(posedge mclk);
            if (sel == 0 && coreOn === 1'b1 && coreReset === 1'b0) break;
            if (sel == 1 && inSleep === 1'b1) break;
            if (sel == 2 && emergencyOff === 1'b1) break;
        end
        if (cnt == bound) timeout();
    endtask
    task automatic expectWake(input int src, input int bound);
        int c;
        logic [31:0] d;
        logic [1:0] r;
        waitFor(0, bound, c);
        axiRead(ulpswk_pkg::ADDR_STATUS, d, r);
        check("state", 32'(d[2:0]), 32'h0000_0002);
        check("cause", 32'(d[3+src]), 32'h0000_0001);
    endtask
    task automatic goSleep(input logic psm);
        int c;
        if (psm) psmIdle <= 1'b1;
        else sleepReq <= 1'b1;
        waitFor(1, 50, c);
        psmIdle <= 1'b0;
        sleepReq <= 1'b0;
        check("coreOn", 32'(coreOn), 32'h0000_0000);
    endtask
    // Comparator level that fires (or stays quiet) for each trigger kind
    function automatic logic [11:0] anVal(input int k, input logic fire, input logic [11:0] lo, hi);
        if (k == 0) return fire ? hi + 12'h064 : lo;
        if (k == 1) return fire ? lo - 12'h064 : hi;
        if (k == 2) return fire ? lo + 12'h0FA : hi + 12'h064;
        return fire ? hi + 12'h064 : lo + 12'h0FA;
    endfunction
    initial begin
        int c, m, p, ch;
        logic idle;
        logic [11:0] lo, hi;
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'hc210));
        ulpswk_board_i.setPower(1'b0);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        waitFor(1, 20, c);
        check("inSleep", 32'(inSleep), 32'h0000_0001);
        ulpswk_board_i.setPower(1'b1);
        expectWake(ulpswk_pkg::SRC_POWER, 80);
        axiRead(32'h0000_0040, d, r);
        check("rresp", 32'(r), 32'(ulpswk_pkg::RESP_SLVERR));
        check("rdata", d, 32'h0000_0000);
        axiWrite(32'h0000_0044, 32'h0000_0001, r);
        check("bresp", 32'(r), 32'(ulpswk_pkg::RESP_SLVERR));
        wr(ulpswk_pkg::ADDR_CTRL, 32'(ulpswk_pkg::MODE_ULPM));
        for (m = 1; m <= 5; m++) begin
            p = m % 2;
            idle = (m == 2 || m == 4) ? 1'b1 : (m == 5 ? 1'($urandom % 2) : 1'b0);
            wr(ulpswk_pkg::ADDR_PINCFG, 32'h0000_0000);
            ulpswk_board_i.setPin(p, idle);
            wr(ulpswk_pkg::ADDR_PINCFG, 32'(m) << (3 * p));
            goSleep(1'b0);
            repeat (200) @(posedge mclk);
            check("asleep", 32'(inSleep), 32'h0000_0001);
            ulpswk_board_i.setPin(p, ~idle);
            expectWake(p ? ulpswk_pkg::SRC_PIN_B : ulpswk_pkg::SRC_PIN_A, 40);
        end
        axiRead(ulpswk_pkg::ADDR_PINCFG, d, r);
        check("pincfg", d, 32'h0000_0028);
        wr(ulpswk_pkg::ADDR_PINCFG, 32'h0000_0000);
        goSleep(1'b0);
        ulpswk_board_i.pulseReset();
        expectWake(ulpswk_pkg::SRC_RESET, 60);
        ulpswk_board_i.setPower(1'b0);
        goSleep(1'b0);
        ulpswk_board_i.pulseReset();
        waitFor(2, 60, c);
        check("coreOn", 32'(coreOn), 32'h0000_0000);
        ulpswk_board_i.setPower(1'b1);
        waitFor(0, 80, c);
        check("epoffBoot", 32'(c >= BOOT), 32'h0000_0001);
        for (m = 0; m < 4; m++) begin
            hi = 12'h5DC + 12'($urandom % 2000);
            lo = hi - 12'h1F4;
            ch = $urandom % 2;
            ulpswk_board_i.setAnalog(0, anVal(m, 1'b0, lo, hi));
            ulpswk_board_i.setAnalog(1, anVal(m, 1'b0, lo, hi));
            wr(ulpswk_pkg::ADDR_ANALOG, {4'h0, 1'b1, 1'(ch), 2'(m), lo, hi});
            goSleep(1'b0);
            ulpswk_board_i.setAnalog(1 - ch, anVal(m, 1'b1, lo, hi));
            repeat (30) @(posedge mclk);
            check("asleep", 32'(inSleep), 32'h0000_0001);
            ulpswk_board_i.setAnalog(ch, anVal(m, 1'b1, lo, hi));
            expectWake(ulpswk_pkg::SRC_ANALOG, 40);
        end
        wr(ulpswk_pkg::ADDR_ANALOG, 32'h0000_0000);
        wr(ulpswk_pkg::ADDR_CTRL, 32'(ulpswk_pkg::MODE_PSM));
        wr(ulpswk_pkg::ADDR_CYCLE, 32'h0000_012C);
        goSleep(1'b1);
        waitFor(0, 400, c);
        check("early", 32'(c >= 236 && c < 300), 32'h0000_0001);
        expectWake(ulpswk_pkg::SRC_LOCAL, 5);
        ulpswk_board_i.setPin(0, 1'b0);
        wr(ulpswk_pkg::ADDR_PINCFG, 32'(ulpswk_pkg::PIN_RISE));
        goSleep(1'b1);
        repeat (20) @(posedge mclk);
        ulpswk_board_i.setPin(0, 1'b1);
        expectWake(ulpswk_pkg::SRC_PIN_A, 40);
        wr(ulpswk_pkg::ADDR_PINCFG, 32'h0000_0000);
        wr(ulpswk_pkg::ADDR_CYCLE, 32'h0000_0000);
        goSleep(1'b1);
        expectWake(ulpswk_pkg::SRC_CYCLE, 40);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        waitFor(0, 40, c);
        axiRead(ulpswk_pkg::ADDR_STATUS, d, r);
        check("powerUpCause", 32'(d[9:3]), 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
